/* File: pcg_top.sv */
// peripheral clock generation with AXI4-Lite registers
// assumes all source clocks arrive as one-cycle ticks on CLOCK
//
// Implementation choices: the AXI4-Lite register port and the register addresses.
module pcg_top (
   // clock and reset
   input  wire logic        CLOCK,
   input  wire logic        RSTN,
   // AXI4-Lite slave
   input  wire logic [7:0]  S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   output logic [1:0]       S_AXI_BRESP,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [7:0]  S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   // source ticks
   input  wire logic        FAST_RC_TICK,
   input  wire logic        MAIN_CRYSTAL_TICK,
   input  wire logic        SLOW_CRYSTAL_TICK,
   input  wire logic        SLOW_RC_TICK,
   input  wire logic        SYSTEM_PLL_TICK,
   input  wire logic        AUDIO_PLL_VCO_TICK,
   input  wire logic        AUDIO_PLL_LOCK,
   // audio PLL controls
   output logic             AUDIO_PLL_POWER_UP,
   output logic [5:0]       AUDIO_PLL_MASTER_DIVIDER,
   output logic [6:0]       AUDIO_PLL_FEEDBACK_DIVIDER,
   output logic [21:0]      AUDIO_PLL_FEEDBACK_FRACTION,
   // serial ports and analog unit
   input  wire logic        SYNC_SERIAL_I2S_MODE,
   output logic             SERIAL_PORT_TICK,
   output logic             SYNC_SERIAL_TICK,
   output logic             ANALOG_UNIT_TICK,
   // timers
   input  wire logic [3:0]  TIMER_CLOCK_SOURCE,
   input  wire logic [3:0]  TIMER_INPUT_MODE,
   output logic [3:0]       TIMER_TICK,
   output logic [3:0]       TIMER_SAMPLE_TICK,
   // clock output pin
   output logic             CLOCK_OUT_PIN,
   output logic             CLOCK_OUT_PIN_EN
);
   localparam int NT = pcg_pkg::N_TIMERS;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb, input logic [31:0] mask);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = data[8*b +: 8];
         end
      end
      return res & mask;
   endfunction

   function automatic logic is_mapped(input logic [7:0] a);
      return (a <= pcg_pkg::OFS_STATUS) && (a[1:0] == 2'h0);
   endfunction

   function automatic logic [6:0] post_ratio(input logic [1:0] pat, input logic [2:0] md);
      case ({pat, md})
         5'h03:   return 7'h01;
         5'h05:   return 7'h02;
         5'h00:   return 7'h04;
         5'h01:   return 7'h08;
         5'h02:   return 7'h10;
         5'h09:   return 7'h06;
         5'h0A:   return 7'h0C;
         5'h0C:   return 7'h18;
         5'h0E:   return 7'h30;
         5'h11:   return 7'h09;
         5'h12:   return 7'h12;
         5'h14:   return 7'h24;
         5'h16:   return 7'h48;
         default: return 7'h00;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave
   logic        awready_reg, wready_reg, aw_full_reg, w_full_reg, bvalid_reg;
   logic        arready_reg, rvalid_reg;
   logic [7:0]  aw_addr_reg;
   logic [31:0] w_data_reg, rdata_reg, rd_data;
   logic [3:0]  w_strb_reg;
   logic [1:0]  bresp_reg, rresp_reg;

   wire aw_take     = S_AXI_AWVALID && awready_reg;
   wire w_take      = S_AXI_WVALID && wready_reg;
   wire wr_fire     = aw_full_reg && w_full_reg && !bvalid_reg;
   wire aw_full_next = (aw_full_reg && !wr_fire) || aw_take;
   wire w_full_next  = (w_full_reg && !wr_fire) || w_take;
   wire bvalid_next = wr_fire || (bvalid_reg && !S_AXI_BREADY);
   wire ar_take     = S_AXI_ARVALID && arready_reg;
   wire rvalid_next = ar_take || (rvalid_reg && !S_AXI_RREADY);
   wire [7:0] wa    = aw_addr_reg;

   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         awready_reg <= 1'b0;
         wready_reg  <= 1'b0;
         aw_full_reg <= 1'b0;
         w_full_reg  <= 1'b0;
         bvalid_reg  <= 1'b0;
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg  <= 32'h00000000;
         w_strb_reg  <= 4'h0;
         bresp_reg   <= pcg_pkg::RESP_OKAY;
         rresp_reg   <= pcg_pkg::RESP_OKAY;
         rdata_reg   <= 32'h00000000;
      end else begin
         aw_full_reg <= aw_full_next;
         w_full_reg  <= w_full_next;
         bvalid_reg  <= bvalid_next;
         rvalid_reg  <= rvalid_next;
         awready_reg <= !aw_full_next && !bvalid_next;
         wready_reg  <= !w_full_next && !bvalid_next;
         arready_reg <= !rvalid_next;
         if (aw_take) aw_addr_reg <= S_AXI_AWADDR;
         if (w_take) begin
            w_data_reg <= S_AXI_WDATA;
            w_strb_reg <= S_AXI_WSTRB;
         end
         if (wr_fire) bresp_reg <= is_mapped(wa) ? pcg_pkg::RESP_OKAY : pcg_pkg::RESP_SLVERR;
         if (ar_take) begin
            rdata_reg <= is_mapped(S_AXI_ARADDR) ? rd_data : 32'h00000000;
            rresp_reg <= is_mapped(S_AXI_ARADDR) ? pcg_pkg::RESP_OKAY : pcg_pkg::RESP_SLVERR;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // control registers
   logic [31:0] src_reg, ser_reg, fast_reg, slow_reg, apla_reg, aplb_reg;
   logic [31:0] gate_reg, peri_reg, per2_reg, cout_reg;
   logic [31:0] tmr_reg [NT];

   wire wr_src  = wr_fire && (wa == pcg_pkg::OFS_SRC_SEL);
   wire wr_ser  = wr_fire && (wa == pcg_pkg::OFS_SER_SEL);
   wire wr_fast = wr_fire && (wa == pcg_pkg::OFS_FAST_DIV);
   wire wr_slow = wr_fire && (wa == pcg_pkg::OFS_SLOW_DIV);
   wire wr_apla = wr_fire && (wa == pcg_pkg::OFS_APLL_A);
   wire wr_aplb = wr_fire && (wa == pcg_pkg::OFS_APLL_B);
   wire wr_gate = wr_fire && (wa == pcg_pkg::OFS_ANA_GATE);
   wire wr_peri = wr_fire && (wa == pcg_pkg::OFS_PERI_EN);
   wire wr_per2 = wr_fire && (wa == pcg_pkg::OFS_PERI2);
   wire wr_cout = wr_fire && (wa == pcg_pkg::OFS_CLKOUT);

   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         src_reg  <= pcg_pkg::RST_ZERO;
         ser_reg  <= pcg_pkg::RST_ZERO;
         fast_reg <= pcg_pkg::RST_ZERO;
         slow_reg <= pcg_pkg::RST_ZERO;
         apla_reg <= pcg_pkg::RST_ZERO;
         aplb_reg <= pcg_pkg::RST_ZERO;
         gate_reg <= pcg_pkg::RST_GATE;
         peri_reg <= pcg_pkg::RST_PERI;
         per2_reg <= pcg_pkg::RST_ZERO;
         cout_reg <= pcg_pkg::RST_ZERO;
      end else begin
         if (wr_src)  src_reg  <= merge(src_reg, w_data_reg, w_strb_reg, pcg_pkg::MASK_SRC);
         if (wr_ser)  ser_reg  <= merge(ser_reg, w_data_reg, w_strb_reg, pcg_pkg::MASK_SER);
         if (wr_fast) fast_reg <= merge(fast_reg, w_data_reg, w_strb_reg, pcg_pkg::MASK_FRAC);
         if (wr_slow) slow_reg <= merge(slow_reg, w_data_reg, w_strb_reg, pcg_pkg::MASK_FRAC);
         if (wr_apla) apla_reg <= merge(apla_reg, w_data_reg, w_strb_reg, pcg_pkg::MASK_APLA);
         if (wr_aplb) aplb_reg <= merge(aplb_reg, w_data_reg, w_strb_reg, pcg_pkg::MASK_APLB);
         if (wr_gate) gate_reg <= merge(gate_reg, w_data_reg, w_strb_reg, pcg_pkg::MASK_GATE);
         if (wr_peri) peri_reg <= merge(peri_reg, w_data_reg, w_strb_reg, pcg_pkg::MASK_PERI);
         if (wr_per2) per2_reg <= merge(per2_reg, w_data_reg, w_strb_reg, pcg_pkg::MASK_PER2);
         if (wr_cout) cout_reg <= merge(cout_reg, w_data_reg, w_strb_reg, pcg_pkg::MASK_COUT);
      end
   end

   for (genvar i = 0; i < NT; i++) begin : g_treg
      wire wr_t = wr_fire && (wa == pcg_pkg::OFS_TMR0 + 8'(4 * i));
      always_ff @(posedge CLOCK or negedge RSTN) begin
         if (!RSTN) begin
            tmr_reg[i] <= pcg_pkg::RST_ZERO;
         end else if (wr_t) begin
            tmr_reg[i] <= merge(tmr_reg[i], w_data_reg, w_strb_reg, pcg_pkg::MASK_TMR);
         end
      end
   end

   wire [31:0] status = {30'h0, AUDIO_PLL_LOCK, apla_reg[pcg_pkg::PWRUP_BIT]};
   wire [7:0]  ra     = S_AXI_ARADDR;

   always_comb begin
      case (ra)
         pcg_pkg::OFS_SRC_SEL:  rd_data = src_reg;
         pcg_pkg::OFS_SER_SEL:  rd_data = ser_reg;
         pcg_pkg::OFS_FAST_DIV: rd_data = fast_reg;
         pcg_pkg::OFS_SLOW_DIV: rd_data = slow_reg;
         pcg_pkg::OFS_APLL_A:   rd_data = apla_reg;
         pcg_pkg::OFS_APLL_B:   rd_data = aplb_reg;
         pcg_pkg::OFS_ANA_GATE: rd_data = gate_reg;
         pcg_pkg::OFS_PERI_EN:  rd_data = peri_reg;
         pcg_pkg::OFS_PERI2:    rd_data = per2_reg;
         pcg_pkg::OFS_CLKOUT:   rd_data = cout_reg;
         pcg_pkg::OFS_STATUS:   rd_data = status;
         default: begin
            if (ra >= pcg_pkg::OFS_TMR0 && ra < pcg_pkg::OFS_PERI2) rd_data = tmr_reg[ra[3:2]];
            else rd_data = 32'h00000000;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // fractional dividers
   wire [1:0] src_sel = src_reg[1:0];
   wire frac_in = (src_sel == pcg_pkg::PCG_SRC_SYS) ? 1'b1 :
                  (src_sel == pcg_pkg::PCG_SRC_MAIN) ? MAIN_CRYSTAL_TICK :
                  (src_sel == pcg_pkg::PCG_SRC_FAST_RC) ? FAST_RC_TICK : 1'b0;
   logic fast_tick, slow_tick;

   pcg_frac_div #(.DEN_W(pcg_pkg::DEN_W), .NUM_W(pcg_pkg::NUM_W)) u_fast (
      .clk      (CLOCK),
      .rst_n    (RSTN),
      .tick_in  (frac_in),
      .den      (fast_reg[pcg_pkg::DEN_LSB +: pcg_pkg::DEN_W]),
      .num      (fast_reg[pcg_pkg::NUM_LSB +: pcg_pkg::NUM_W]),
      .tick_out (fast_tick)
   );
   pcg_frac_div #(.DEN_W(pcg_pkg::DEN_W), .NUM_W(pcg_pkg::NUM_W)) u_slow (
      .clk      (CLOCK),
      .rst_n    (RSTN),
      .tick_in  (frac_in),
      .den      (slow_reg[pcg_pkg::DEN_LSB +: pcg_pkg::DEN_W]),
      .num      (slow_reg[pcg_pkg::NUM_LSB +: pcg_pkg::NUM_W]),
      .tick_out (slow_tick)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // audio PLL post-divider
   wire pll_on = apla_reg[pcg_pkg::PWRUP_BIT];
   wire [6:0] ratio = post_ratio(aplb_reg[pcg_pkg::PAT_LSB +: pcg_pkg::PAT_W],
                                 aplb_reg[pcg_pkg::MOD_LSB +: pcg_pkg::MOD_W]);
   logic audio_tick;

   pcg_frac_div #(.DEN_W(1), .NUM_W(pcg_pkg::RATIO_W)) u_post (
      .clk      (CLOCK),
      .rst_n    (RSTN),
      .tick_in  (AUDIO_PLL_VCO_TICK && pll_on),
      .den      (1'b1),
      .num      (ratio),
      .tick_out (audio_tick)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // timers
   wire [pcg_pkg::SMP_W-1:0] smp_div = per2_reg[pcg_pkg::SMP_LSB +: pcg_pkg::SMP_W];
   logic smp_tick;
   logic [NT-1:0] tdiv_tick;

   pcg_frac_div #(.DEN_W(1), .NUM_W(pcg_pkg::SMP_W)) u_smp (
      .clk      (CLOCK),
      .rst_n    (RSTN),
      .tick_in  (1'b1),
      .den      (1'b1),
      .num      ((smp_div == '0) ? pcg_pkg::SMP_W'(1) : smp_div),
      .tick_out (smp_tick)
   );

   for (genvar i = 0; i < NT; i++) begin : g_tmr
      wire [1:0] sel  = tmr_reg[i][pcg_pkg::TSEL_LSB +: pcg_pkg::TSEL_W];
      wire slow_pick  = tmr_reg[i][pcg_pkg::TSLOW_BIT];
      wire [5:0] dv   = (i == NT - 1) ?
                        {per2_reg[pcg_pkg::T3HI_LSB +: pcg_pkg::T3PART_W],
                         per2_reg[pcg_pkg::T3LO_LSB +: pcg_pkg::T3PART_W]} :
                        tmr_reg[i][pcg_pkg::TDIV_LSB +: pcg_pkg::TDIV_W];
      wire divided    = (sel != pcg_pkg::PCG_TSEL_SLOW);
      wire [5:0] n    = (!divided || dv == 6'h00) ? 6'h01 : dv;
      wire t_in = (sel == pcg_pkg::PCG_TSEL_SYS) ? 1'b1 :
                  (sel == pcg_pkg::PCG_TSEL_FRC) ? FAST_RC_TICK :
                  (sel == pcg_pkg::PCG_TSEL_MAIN) ? MAIN_CRYSTAL_TICK :
                  (slow_pick ? SLOW_RC_TICK : SLOW_CRYSTAL_TICK);
      pcg_frac_div #(.DEN_W(1), .NUM_W(pcg_pkg::TDIV_W)) u_tdiv (
         .clk      (CLOCK),
         .rst_n    (RSTN),
         .tick_in  (t_in),
         .den      (1'b1),
         .num      (n),
         .tick_out (tdiv_tick[i])
      );
   end

   ////////////////////////////////////////////////////////////////////////////////
   // output stage
   wire [2:0] cout_sel = cout_reg[pcg_pkg::COUT_LSB +: pcg_pkg::COUT_W];
   wire cout_src = (cout_sel == pcg_pkg::COUT_SLOW_XTAL) ? SLOW_CRYSTAL_TICK :
                   (cout_sel == pcg_pkg::COUT_SLOW_RC)   ? SLOW_RC_TICK :
                   (cout_sel == pcg_pkg::COUT_FAST_RC)   ? FAST_RC_TICK :
                   (cout_sel == pcg_pkg::COUT_AUDIO)     ? audio_tick :
                   (cout_sel == pcg_pkg::COUT_SYS_PLL)   ? SYSTEM_PLL_TICK : 1'b0;
   wire [NT-1:0] t_run = ~peri_reg[NT-1:0] & ~TIMER_CLOCK_SOURCE;

   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         SERIAL_PORT_TICK  <= 1'b0;
         SYNC_SERIAL_TICK  <= 1'b0;
         ANALOG_UNIT_TICK  <= 1'b0;
         TIMER_TICK        <= 4'h0;
         TIMER_SAMPLE_TICK <= 4'h0;
         CLOCK_OUT_PIN     <= 1'b0;
         CLOCK_OUT_PIN_EN  <= 1'b0;
      end else begin
         SERIAL_PORT_TICK  <= ser_reg[0] ? slow_tick : fast_tick;
         SYNC_SERIAL_TICK  <= SYNC_SERIAL_I2S_MODE ? audio_tick : 1'b1;
         ANALOG_UNIT_TICK  <= audio_tick && gate_reg[0];
         TIMER_TICK        <= tdiv_tick & t_run;
         TIMER_SAMPLE_TICK <= {NT{smp_tick}} & TIMER_INPUT_MODE;
         CLOCK_OUT_PIN     <= cout_src && cout_reg[pcg_pkg::COUT_EN];
         CLOCK_OUT_PIN_EN  <= cout_reg[pcg_pkg::COUT_EN];
      end
   end

   assign S_AXI_AWREADY = awready_reg;
   assign S_AXI_WREADY  = wready_reg;
   assign S_AXI_BVALID  = bvalid_reg;
   assign S_AXI_BRESP   = bresp_reg;
   assign S_AXI_ARREADY = arready_reg;
   assign S_AXI_RVALID  = rvalid_reg;
   assign S_AXI_RDATA   = rdata_reg;
   assign S_AXI_RRESP   = rresp_reg;
   assign AUDIO_PLL_POWER_UP          = apla_reg[pcg_pkg::PWRUP_BIT];
   assign AUDIO_PLL_MASTER_DIVIDER    = aplb_reg[pcg_pkg::MDIV_LSB +: pcg_pkg::MDIV_W];
   assign AUDIO_PLL_FEEDBACK_DIVIDER  = aplb_reg[pcg_pkg::FBDIV_LSB +: pcg_pkg::FBDIV_W];
   assign AUDIO_PLL_FEEDBACK_FRACTION = apla_reg[pcg_pkg::FEEDBACK_FRACTION_LSB +: pcg_pkg::FEEDBACK_FRACTION_W];
endmodule

/* File: pcg_pkg.sv */
// constants for the peripheral clock generation block
// assumes one 200 MHz system clock; other sources arrive as tick enables
package pcg_pkg;
   localparam int ADDR_W   = 8;
   localparam int N_TIMERS = 4;

   // register byte offsets
   localparam logic [7:0] OFS_SRC_SEL  = 8'h00;
   localparam logic [7:0] OFS_SER_SEL  = 8'h04;
   localparam logic [7:0] OFS_FAST_DIV = 8'h08;
   localparam logic [7:0] OFS_SLOW_DIV = 8'h0C;
   localparam logic [7:0] OFS_APLL_A   = 8'h10;
   localparam logic [7:0] OFS_APLL_B   = 8'h14;
   localparam logic [7:0] OFS_ANA_GATE = 8'h18;
   localparam logic [7:0] OFS_PERI_EN  = 8'h1C;
   localparam logic [7:0] OFS_TMR0     = 8'h20;
   localparam logic [7:0] OFS_PERI2    = 8'h30;
   localparam logic [7:0] OFS_CLKOUT   = 8'h34;
   localparam logic [7:0] OFS_STATUS   = 8'h38;

   // writable bits of each register
   localparam logic [31:0] MASK_SRC  = 32'h00000003;
   localparam logic [31:0] MASK_SER  = 32'h00000001;
   localparam logic [31:0] MASK_FRAC = 32'h00FFFFFF;
   localparam logic [31:0] MASK_APLA = 32'h803FFFFF;
   localparam logic [31:0] MASK_APLB = 32'h00377F3F;
   localparam logic [31:0] MASK_GATE = 32'h00000001;
   localparam logic [31:0] MASK_PERI = 32'h0000000F;
   localparam logic [31:0] MASK_TMR  = 32'h000003F7;
   localparam logic [31:0] MASK_PER2 = 32'h00000F3F;
   localparam logic [31:0] MASK_COUT = 32'h00000017;

   // reset values
   localparam logic [31:0] RST_ZERO = 32'h00000000;
   localparam logic [31:0] RST_GATE = 32'h00000001;
   localparam logic [31:0] RST_PERI = 32'h0000000F;

   // field layout
   localparam int DEN_LSB   = 0;
   localparam int DEN_W     = 11;
   localparam int NUM_LSB   = 11;
   localparam int NUM_W     = 13;
   localparam int FEEDBACK_FRACTION_LSB = 0;
   localparam int FEEDBACK_FRACTION_W   = 22;
   localparam int PWRUP_BIT = 31;
   localparam int MDIV_LSB  = 0;
   localparam int MDIV_W    = 6;
   localparam int FBDIV_LSB = 8;
   localparam int FBDIV_W   = 7;
   localparam int MOD_LSB   = 16;
   localparam int MOD_W     = 3;
   localparam int PAT_LSB   = 20;
   localparam int PAT_W     = 2;
   localparam int RATIO_W   = 7;
   localparam int TSEL_LSB  = 0;
   localparam int TSEL_W    = 2;
   localparam int TSLOW_BIT = 2;
   localparam int TDIV_LSB  = 4;
   localparam int TDIV_W    = 6;
   localparam int T3LO_LSB  = 0;
   localparam int T3HI_LSB  = 3;
   localparam int T3PART_W  = 3;
   localparam int SMP_LSB   = 8;
   localparam int SMP_W     = 4;
   localparam int COUT_LSB  = 0;
   localparam int COUT_W    = 3;
   localparam int COUT_EN   = 4;
   localparam int ST_PWR    = 0;
   localparam int ST_LOCK   = 1;

   // source codes
   typedef enum logic [1:0] {
      PCG_SRC_FAST_RC = 2'h0,
      PCG_SRC_MAIN    = 2'h1,
      PCG_SRC_SYS     = 2'h2
   } pcg_src_t;
   typedef enum logic [1:0] {
      PCG_TSEL_SYS  = 2'h0,
      PCG_TSEL_FRC  = 2'h1,
      PCG_TSEL_MAIN = 2'h2,
      PCG_TSEL_SLOW = 2'h3
   } pcg_tsel_t;
   localparam logic [2:0] COUT_SLOW_XTAL = 3'h0;
   localparam logic [2:0] COUT_SLOW_RC   = 3'h1;
   localparam logic [2:0] COUT_FAST_RC   = 3'h2;
   localparam logic [2:0] COUT_AUDIO     = 3'h3;
   localparam logic [2:0] COUT_SYS_PLL   = 3'h4;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: pcg_frac_div.sv */
// phase-accumulator divider on a tick enable
// assumes den <= num; den > num gives one pulse per input tick
module pcg_frac_div #(
   parameter int DEN_W = 11,
   parameter int NUM_W = 13
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // source and settings
   input  wire logic             tick_in,
   input  wire logic [DEN_W-1:0] den,
   input  wire logic [NUM_W-1:0] num,
   // divided tick
   output logic                  tick_out
);
   logic [NUM_W-1:0] acc_reg;
   logic [DEN_W-1:0] den_reg;
   logic [NUM_W-1:0] num_reg;

   wire [NUM_W:0] sum    = {1'b0, acc_reg} + (NUM_W+1)'(den_reg);
   wire [NUM_W:0] rem    = sum - {1'b0, num_reg};
   wire           idle   = (num_reg == '0);
   wire           fire   = tick_in && !idle && (sum >= {1'b0, num_reg});
   wire           fits   = rem < {1'b0, num_reg};
   wire [NUM_W-1:0] rem_next = fits ? rem[NUM_W-1:0] : '0;

   // new settings only at an output edge or while idle, so no short pulse
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_reg  <= '0;
         den_reg  <= '0;
         num_reg  <= '0;
         tick_out <= 1'b0;
      end else begin
         tick_out <= fire;
         if (fire || idle) begin
            den_reg <= den;
            num_reg <= num;
            acc_reg <= idle ? '0 : rem_next;
         end else if (tick_in) begin
            acc_reg <= sum[NUM_W-1:0];
         end
      end
   end
endmodule

/* File: pcg_asserts.sv */
// checker for the peripheral clock generation block
// sees only top ports; bound from the testbench top file
module pcg_asserts (
   // clock and reset
   input wire logic       CLOCK,
   input wire logic       RSTN,
   // register bus
   input wire logic       S_AXI_AWVALID,
   input wire logic       S_AXI_AWREADY,
   input wire logic       S_AXI_WVALID,
   input wire logic       S_AXI_WREADY,
   input wire logic       S_AXI_BVALID,
   input wire logic       S_AXI_BREADY,
   input wire logic       S_AXI_ARVALID,
   input wire logic       S_AXI_ARREADY,
   input wire logic       S_AXI_RVALID,
   input wire logic       S_AXI_RREADY,
   // clock controls
   input wire logic       AUDIO_PLL_POWER_UP,
   input wire logic       SYNC_SERIAL_I2S_MODE,
   input wire logic       SYNC_SERIAL_TICK,
   input wire logic [3:0] TIMER_CLOCK_SOURCE,
   input wire logic [3:0] TIMER_TICK
);
   ////////////////////////////////////////
   default clocking @(posedge CLOCK);
   endclocking
   default disable iff (!RSTN);
   sequence wr_taken;
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
   endsequence
   sequence b_late;
      !S_AXI_BVALID ##1 S_AXI_BVALID;
   endsequence
   wr_answer_a: assert property (wr_taken |=> b_late)
      else $error("write answer off time");
   rd_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read answer late");
   b_drop_a: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
      else $error("write answer kept");
   r_drop_a: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
      else $error("read answer kept");
   aw_block_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
      else $error("write taken while answering");
   ar_block_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
      else $error("read taken while answering");
   pwr_by_write_a: assert property ($rose(AUDIO_PLL_POWER_UP) |-> $rose(S_AXI_BVALID))
      else $error("pll powered without write");
   sync_free_a: assert property (RSTN && !SYNC_SERIAL_I2S_MODE |=> SYNC_SERIAL_TICK)
      else $error("serial tick missing");
   tmr_src_gate_a: assert property (TIMER_CLOCK_SOURCE[0] [*4] |-> !TIMER_TICK[0])
      else $error("timer tick with foreign source");
endmodule

/* File: testbench.sv */
// self-checking bench for the peripheral clock generation block
// source ticks made here; bus ready inputs held high
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        CLOCK, RSTN, AUDIO_PLL_LOCK, SYNC_SERIAL_I2S_MODE, AUDIO_PLL_POWER_UP;
   logic        S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID;
   logic        S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
   logic        FAST_RC_TICK, MAIN_CRYSTAL_TICK, SLOW_CRYSTAL_TICK, SLOW_RC_TICK;
   logic        SYSTEM_PLL_TICK, AUDIO_PLL_VCO_TICK, SERIAL_PORT_TICK, SYNC_SERIAL_TICK;
   logic        ANALOG_UNIT_TICK, CLOCK_OUT_PIN, CLOCK_OUT_PIN_EN;
   logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, rr;
   logic [3:0]  S_AXI_WSTRB, TIMER_CLOCK_SOURCE, TIMER_INPUT_MODE, TIMER_TICK, TIMER_SAMPLE_TICK;
   logic [5:0]  AUDIO_PLL_MASTER_DIVIDER;
   logic [6:0]  AUDIO_PLL_FEEDBACK_DIVIDER;
   logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR;
   logic [21:0] AUDIO_PLL_FEEDBACK_FRACTION;
   logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rv;
   logic [31:0] cnt [6];
   logic [31:0] tctl [5] = '{32'h40, 32'h31, 32'h22, 32'h43, 32'h47};
   int          texp [5] = '{360, 240, 240, 180, 90};
   int          pr [13] = '{1, 2, 4, 6, 8, 9, 12, 16, 18, 24, 36, 48, 72};
   logic [4:0]  pc [13] = '{5'h03, 5'h05, 5'h00, 5'h09, 5'h01, 5'h11, 5'h0A, 5'h02, 5'h12,
                            5'h0C, 5'h14, 5'h0E, 5'h16};
   int          cyc = 0, num_errors = 0, n_tests = 0;
   pcg_top i_pcg_top (.*);
   ////////////////////////////////////////
   initial begin
      CLOCK = 1'b0;
      forever #2.5 CLOCK = ~CLOCK;
   end
   always @(posedge CLOCK) begin
      cyc <= cyc + 1;
      {FAST_RC_TICK, MAIN_CRYSTAL_TICK} <= {cyc % 2 == 0, cyc % 3 == 0};
      {SLOW_CRYSTAL_TICK, SLOW_RC_TICK} <= {cyc % 8 == 0, cyc % 16 == 0};
   end
   task chk(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         num_errors++;
         $display("BAD %0t seen %h want %h", $time, s, e);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= d;
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID <= 1'b1;
      do begin
         @(posedge CLOCK);
         if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
         if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      end while (S_AXI_BVALID !== 1'b1);
      rr = S_AXI_BRESP;
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] e);
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1'b1;
      do begin
         @(posedge CLOCK);
         if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      end while (S_AXI_RVALID !== 1'b1);
      rr = S_AXI_RRESP;
      chk(S_AXI_RDATA, e);
   endtask
   // settle, then count pulses over a window of 1440 cycles
   task run;
      logic [5:0] v;
      cnt = '{default: 32'h0};
      repeat (200) @(posedge CLOCK);
      repeat (1440) begin
         @(posedge CLOCK);
         v = {SERIAL_PORT_TICK, ANALOG_UNIT_TICK, SYNC_SERIAL_TICK, TIMER_TICK[0], TIMER_TICK[3],
              TIMER_SAMPLE_TICK[0]};
         for (int k = 0; k < 6; k++) cnt[k] += {31'h0, v[k]};
      end
   endtask
   task finish_test;
      $display("errors %0d checks %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge CLOCK);
      num_errors++;
      finish_test;
   end
   initial begin
      {RSTN, AUDIO_PLL_LOCK, SYNC_SERIAL_I2S_MODE, S_AXI_AWVALID, S_AXI_WVALID} = '0;
      {S_AXI_ARVALID, S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = '0;
      {S_AXI_BREADY, S_AXI_RREADY, SYSTEM_PLL_TICK, AUDIO_PLL_VCO_TICK, S_AXI_WSTRB} = '1;
      {TIMER_CLOCK_SOURCE, TIMER_INPUT_MODE} = 8'h0F;
      repeat (20) @(posedge CLOCK);
      RSTN <= 1'b1;
      @(posedge CLOCK);
      rdc(8'h18, 32'h1);
      rdc(8'h1C, 32'hF);
      rdc(8'h10, 32'h0);
      wr(8'h08, 32'hFFFFFFFF);
      chk({30'h0, rr}, 32'h0);
      rdc(8'h08, 32'h00FFFFFF);
      rdc(8'h3C, 32'h0);
      chk({30'h0, rr}, 32'h2);
      wr(8'h3C, 32'h1);
      chk({30'h0, rr}, 32'h2);
      wr(8'h00, 32'h2);
      wr(8'h08, 32'h4003);
      wr(8'h0C, 32'h2801);
      run;
      chk(cnt[5], 32'd540);
      wr(8'h04, 32'h1);
      run;
      chk(cnt[5], 32'd288);
      wr(8'h00, 32'h1);
      wr(8'h04, 32'h0);
      run;
      chk(cnt[5], 32'd180);
      wr(8'h20, 32'h40);
      run;
      chk(cnt[2], 32'd0);
      wr(8'h1C, 32'h0);
      wr(8'h30, 32'h506);
      for (int i = 0; i < 5; i++) begin
         wr(8'h20, tctl[i]);
         run;
         chk(cnt[2], 32'(texp[i]));
      end
      chk(cnt[1], 32'd240);
      chk(cnt[0], 32'd288);
      {TIMER_CLOCK_SOURCE, TIMER_INPUT_MODE} <= 8'h1E;
      {SYNC_SERIAL_I2S_MODE, AUDIO_PLL_LOCK} <= 2'h3;
      run;
      chk(cnt[2], 32'd0);
      chk(cnt[0], 32'd0);
      chk(cnt[4], 32'd0);
      wr(8'h14, 32'h0000230A);
      wr(8'h10, 32'h00008208);
      chk({19'h0, AUDIO_PLL_FEEDBACK_DIVIDER, AUDIO_PLL_MASTER_DIVIDER}, {19'h0, 7'h23, 6'h0A});
      chk({10'h0, AUDIO_PLL_FEEDBACK_FRACTION}, 32'h00008208);
      chk({31'h0, AUDIO_PLL_POWER_UP}, 32'h0);
      wr(8'h10, 32'h80008208);
      chk({31'h0, AUDIO_PLL_POWER_UP}, 32'h1);
      rdc(8'h38, 32'h3);
      for (int i = 0; i < 13; i++) begin
         wr(8'h14, {10'h000, pc[i][4:3], 1'b0, pc[i][2:0], 1'b0, 7'h23, 2'h0, 6'h0A});
         run;
         chk(cnt[4], 32'(1440 / pr[i]));
         chk(cnt[3], 32'(1440 / pr[i]));
      end
      wr(8'h18, 32'h0);
      run;
      chk(cnt[4], 32'd0);
      chk(cnt[3], 32'd20);
      wr(8'h34, 32'h12);
      repeat (3) @(posedge CLOCK);
      chk({31'h0, CLOCK_OUT_PIN_EN}, 32'h1);
      rv = 32'h0;
      repeat (8) begin
         @(posedge CLOCK);
         rv += {31'h0, CLOCK_OUT_PIN};
      end
      chk(rv, 32'h4);
      finish_test;
   end
endmodule

bind pcg_top pcg_asserts i_pcg_asserts (.*);
